// ### src/qdac_cfg.svh
// Constants of the quad converter command port: address, frame layout, codes, reset values
`ifndef QDAC_CFG_SVH
`define QDAC_CFG_SVH
`define QDAC_ADDR_FIXED     5'h03
`define QDAC_CMD_POS        20
`define QDAC_SEL_POS        16
`define QDAC_CMD_NOP        4'h0
`define QDAC_CMD_WR_INPUT   4'h1
`define QDAC_CMD_UPDATE     4'h2
`define QDAC_CMD_WR_UPDATE  4'h3
`define QDAC_CMD_PWR        4'h4
`define QDAC_FRAME_W        24
`define QDAC_FIFO_DEPTH     16
`define QDAC_CODE_RST       16'h0000
`define QDAC_PWR_RST        8'h00
`endif

// ### src/qdac_command_port.sv
// Quad converter two-wire command port with frame FIFO and double-buffered registers
`timescale 1ns/1ps
`default_nettype none
`include "qdac_cfg.svh"

module qdac_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    input  wire logic             mclk,
    input  wire logic             resetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wptr;
        logic [AW-1:0]               rptr;
        logic [AW:0]                 count;
    } fifo_s;
    fifo_s st_reg;
    fifo_s st_next;
    logic  push;
    logic  pop;

    assign in_ready  = (st_reg.count != DEPTH[AW:0]);
    assign out_valid = (st_reg.count != '0);
    assign out_data  = st_reg.mem[st_reg.rptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.mem[st_reg.wptr] = in_data;
            st_next.wptr             = st_reg.wptr + 1'b1;
        end
        if (pop) begin
            st_next.rptr = st_reg.rptr + 1'b1;
        end
        st_next.count = st_reg.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule : qdac_fifo

module qdac_command_port (
    input  wire logic         mclk,
    input  wire logic         resetn,
    input  wire logic         scl_i,
    input  wire logic         sda_i,
    output logic              sda_o,
    output logic              sda_oe,
    input  wire logic         addr_pin_hi,
    input  wire logic         addr_pin_lo,
    input  wire logic         load_outputs_n,
    output qdac_pkg::qdac_bank_t input_reg,
    output qdac_pkg::qdac_bank_t dac_reg,
    output qdac_pkg::qdac_pwr_t  chan_pwr_mode,
    output logic              frame_busy
);
    import qdac_pkg::*;

    typedef struct packed {
        logic [2:0]  scl_sy;
        logic [2:0]  sda_sy;
        logic [2:0]  ld_sy;
        logic [1:0]  ahi_sy;
        logic [1:0]  alo_sy;
        qdac_state_e state;
        logic [3:0]  cnt;
        logic [1:0]  byte_idx;
        logic        rw;
        logic [7:0]  sh;
        logic [7:0]  cmd;
        logic [7:0]  hi;
        logic [7:0]  tx;
        logic [1:0]  rd_ch;
        logic        rd_lo;
        logic        sda_o;
        logic        sda_oe;
        qdac_bank_t  inp;
        qdac_bank_t  dac;
        qdac_pwr_t   pwr;
        logic        busy;
    } qdac_s;

    qdac_s       st_reg;
    qdac_s       st_next;
    logic        scl_rise;
    logic        scl_fall;
    logic        bus_start;
    logic        bus_stop;
    logic        ld_fall;
    logic        addr_match;
    logic        f_in_valid;
    logic        f_in_ready;
    logic [23:0] f_in_data;
    logic        f_out_valid;
    logic        f_out_ready;
    logic [23:0] f_out_data;
    logic        pop;
    logic [3:0]  f_cmd;
    logic [3:0]  f_sel;

    // Edge finders read only the second and third synchroniser stages
    assign scl_rise   = st_reg.scl_sy[1] && !st_reg.scl_sy[2];
    assign scl_fall   = !st_reg.scl_sy[1] && st_reg.scl_sy[2];
    assign bus_start  = st_reg.scl_sy[1] && st_reg.scl_sy[2]
                        && !st_reg.sda_sy[1] && st_reg.sda_sy[2];
    assign bus_stop   = st_reg.scl_sy[1] && st_reg.scl_sy[2]
                        && st_reg.sda_sy[1] && !st_reg.sda_sy[2];
    assign ld_fall    = !st_reg.ld_sy[1] && st_reg.ld_sy[2];
    assign addr_match = (st_reg.sh[7:1] ==
                         {`QDAC_ADDR_FIXED, st_reg.ahi_sy[1], st_reg.alo_sy[1]});
    assign f_cmd       = f_out_data[`QDAC_CMD_POS +: 4];
    assign f_sel       = f_out_data[`QDAC_SEL_POS +: 4];
    // A load edge takes the cycle, so the frame queue waits
    assign f_out_ready = !ld_fall;
    assign pop         = f_out_valid && f_out_ready;
    assign f_in_data   = {st_reg.cmd, st_reg.hi, st_reg.sh};
    assign f_in_valid  = (st_reg.state == QDAC_RX) && scl_fall && (st_reg.cnt == 4'h8)
                         && (st_reg.byte_idx == 2'h2);

    qdac_fifo #(
        .WIDTH (`QDAC_FRAME_W),
        .DEPTH (`QDAC_FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .resetn    (resetn),
        .in_valid  (f_in_valid),
        .in_ready  (f_in_ready),
        .in_data   (f_in_data),
        .out_valid (f_out_valid),
        .out_ready (f_out_ready),
        .out_data  (f_out_data)
    );

    always_comb begin
        st_next        = st_reg;
        st_next.scl_sy = {st_reg.scl_sy[1:0], scl_i};
        st_next.sda_sy = {st_reg.sda_sy[1:0], sda_i};
        st_next.ld_sy  = {st_reg.ld_sy[1:0], load_outputs_n};
        st_next.ahi_sy = {st_reg.ahi_sy[0], addr_pin_hi};
        st_next.alo_sy = {st_reg.alo_sy[0], addr_pin_lo};
        st_next.sda_o  = 1'b0;

        // Serial engine; SDA drive only moves on SCL falling edges
        unique case (st_reg.state)
            QDAC_IDLE, QDAC_IGNORE: begin
                st_next.sda_oe = 1'b0;
            end
            QDAC_ADDR: begin
                if (scl_rise) begin
                    st_next.sh  = {st_reg.sh[6:0], st_reg.sda_sy[1]};
                    st_next.cnt = st_reg.cnt + 4'h1;
                end else if (scl_fall && st_reg.cnt == 4'h8) begin
                    st_next.rw = st_reg.sh[0];
                    if (addr_match) begin
                        st_next.sda_oe = 1'b1;
                        st_next.state  = QDAC_ADDR_ACK;
                    end else begin
                        st_next.state = QDAC_IGNORE;
                    end
                end
            end
            QDAC_ADDR_ACK: begin
                if (scl_fall) begin
                    st_next.cnt = 4'h0;
                    if (st_reg.rw) begin
                        st_next.tx     = st_reg.inp[st_reg.rd_ch][15:8];
                        st_next.rd_lo  = 1'b0;
                        st_next.sda_oe = !st_reg.inp[st_reg.rd_ch][15];
                        st_next.state  = QDAC_TX;
                    end else begin
                        st_next.sda_oe   = 1'b0;
                        st_next.byte_idx = 2'h0;
                        st_next.state    = QDAC_RX;
                    end
                end
            end
            QDAC_RX: begin
                if (scl_rise) begin
                    st_next.sh  = {st_reg.sh[6:0], st_reg.sda_sy[1]};
                    st_next.cnt = st_reg.cnt + 4'h1;
                end else if (scl_fall && st_reg.cnt == 4'h8) begin
                    st_next.state = QDAC_RX_ACK;
                    unique case (st_reg.byte_idx)
                        2'h0: begin
                            st_next.cmd    = st_reg.sh;
                            st_next.sda_oe = 1'b1;
                            st_next.busy   = 1'b1;
                            // Readback pointer; several selects fall back to A
                            unique case (st_reg.sh[3:0])
                                4'h2:    st_next.rd_ch = 2'h1;
                                4'h4:    st_next.rd_ch = 2'h2;
                                4'h8:    st_next.rd_ch = 2'h3;
                                default: st_next.rd_ch = 2'h0;
                            endcase
                        end
                        2'h1: begin
                            st_next.hi     = st_reg.sh;
                            st_next.sda_oe = 1'b1;
                        end
                        2'h2: begin
                            // Full queue refuses the frame with a nack
                            st_next.sda_oe = f_in_ready;
                            st_next.busy   = 1'b0;
                        end
                        default: st_next.sda_oe = 1'b0;
                    endcase
                end
            end
            QDAC_RX_ACK: begin
                if (scl_fall) begin
                    st_next.sda_oe = 1'b0;
                    st_next.cnt    = 4'h0;
                    st_next.state  = QDAC_RX;
                    if (st_reg.byte_idx != 2'h3) begin
                        st_next.byte_idx = st_reg.byte_idx + 2'h1;
                    end
                end
            end
            QDAC_TX: begin
                if (scl_rise) begin
                    st_next.cnt = st_reg.cnt + 4'h1;
                end else if (scl_fall) begin
                    if (st_reg.cnt == 4'h8) begin
                        st_next.sda_oe = 1'b0;
                        st_next.state  = QDAC_TX_ACK;
                    end else begin
                        st_next.sda_oe = !st_reg.tx[3'h7 - st_reg.cnt[2:0]];
                    end
                end
            end
            QDAC_TX_ACK: begin
                if (scl_rise && st_reg.sda_sy[1]) begin
                    st_next.state = QDAC_IGNORE;
                end else if (scl_fall) begin
                    st_next.cnt   = 4'h0;
                    st_next.state = QDAC_TX;
                    if (!st_reg.rd_lo) begin
                        st_next.tx     = st_reg.inp[st_reg.rd_ch][7:0];
                        st_next.rd_lo  = 1'b1;
                        st_next.sda_oe = !st_reg.inp[st_reg.rd_ch][7];
                    end else begin
                        // Two-bit pointer wraps D to A
                        st_next.rd_ch  = st_reg.rd_ch + 2'h1;
                        st_next.tx     = st_reg.inp[st_reg.rd_ch + 2'h1][15:8];
                        st_next.rd_lo  = 1'b0;
                        st_next.sda_oe = !st_reg.inp[st_reg.rd_ch + 2'h1][15];
                    end
                end
            end
        endcase

        // Start wins anywhere, including repeated start
        if (bus_start) begin
            st_next.state  = QDAC_ADDR;
            st_next.cnt    = 4'h0;
            st_next.sda_oe = 1'b0;
        end else if (bus_stop) begin
            st_next.state  = QDAC_IDLE;
            st_next.sda_oe = 1'b0;
            st_next.busy   = 1'b0;
        end

        // Double buffer: load low or its falling edge copies input to output
        if (!st_reg.ld_sy[1] || ld_fall) begin
            st_next.dac = st_reg.inp;
        end

        if (pop) begin
            for (int ch = 0; ch < 4; ch++) begin
                if (f_sel[ch]) begin
                    unique case (f_cmd)
                        `QDAC_CMD_WR_INPUT: begin
                            st_next.inp[ch] = f_out_data[15:0];
                            if (!st_reg.ld_sy[1]) begin
                                st_next.dac[ch] = f_out_data[15:0];
                            end
                        end
                        `QDAC_CMD_UPDATE: st_next.dac[ch] = st_reg.inp[ch];
                        `QDAC_CMD_WR_UPDATE: begin
                            st_next.inp[ch] = f_out_data[15:0];
                            st_next.dac[ch] = f_out_data[15:0];
                        end
                        default: ;
                    endcase
                end
            end
            // Selects and middle byte ignored; registers untouched
            if (f_cmd == `QDAC_CMD_PWR) begin
                st_next.pwr = f_out_data[7:0];
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_reg        <= '0;
            st_reg.scl_sy <= 3'h7;
            st_reg.sda_sy <= 3'h7;
            st_reg.ld_sy  <= 3'h7;
            st_reg.state  <= QDAC_IDLE;
            st_reg.inp    <= {4{`QDAC_CODE_RST}};
            st_reg.dac    <= {4{`QDAC_CODE_RST}};
            st_reg.pwr    <= `QDAC_PWR_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign sda_o         = st_reg.sda_o;
    assign sda_oe        = st_reg.sda_oe;
    assign input_reg     = st_reg.inp;
    assign dac_reg       = st_reg.dac;
    assign chan_pwr_mode = st_reg.pwr;
    assign frame_busy    = st_reg.busy;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    sequence s_frame_pop(logic [3:0] c);
        pop && f_cmd == c && f_sel[0];
    endsequence
    sequence s_wrap_step;
        st_reg.state == QDAC_TX_ACK && scl_fall && st_reg.rd_lo && st_reg.rd_ch == 2'h3
        && !bus_start && !bus_stop;
    endsequence

    a_load_transparent: assert property (
        !st_reg.ld_sy[1] && !st_reg.ld_sy[2] |=> st_reg.dac == st_reg.inp)
        else $error("load low did not pass input to output");
    a_load_edge_copy: assert property (
        ld_fall ##1 !f_out_valid |-> st_reg.dac == $past(st_reg.inp))
        else $error("load edge did not copy input registers");
    a_write_input: assert property (
        s_frame_pop(`QDAC_CMD_WR_INPUT) |=> st_reg.inp[0] == $past(f_out_data[15:0]))
        else $error("write-input did not store data");
    a_update_copy: assert property (
        s_frame_pop(`QDAC_CMD_UPDATE) |=> st_reg.dac[0] == $past(st_reg.inp[0]))
        else $error("update did not copy input register");
    a_write_update: assert property (
        s_frame_pop(`QDAC_CMD_WR_UPDATE) |=> st_reg.dac[0] == $past(f_out_data[15:0])
        && st_reg.inp[0] == $past(f_out_data[15:0]))
        else $error("write-and-update missed a register");
    a_power_mode: assert property (
        pop && f_cmd == `QDAC_CMD_PWR |=> st_reg.pwr == $past(f_out_data[7:0])
        && $stable(st_reg.inp))
        else $error("power command mode field wrong");
    a_addr_ack: assert property (
        st_reg.state == QDAC_ADDR && scl_fall && st_reg.cnt == 4'h8 && addr_match
        && !bus_start && !bus_stop |=> st_reg.sda_oe && st_reg.state == QDAC_ADDR_ACK)
        else $error("matching address not acknowledged");
    a_sda_stable: assert property (
        st_reg.scl_sy[1] && st_reg.scl_sy[2] && !bus_start && !bus_stop |=> $stable(sda_oe))
        else $error("sda drive changed while scl high");
    a_wrap_around: assert property (
        s_wrap_step |=> st_reg.rd_ch == 2'h0 ##0 st_reg.tx == st_reg.inp[0][15:8])
        else $error("readback did not wrap to channel A");
    a_ignore_quiet: assert property (
        st_reg.state == QDAC_IGNORE |=> !sda_oe [*2])
        else $error("sda driven for another address");
endmodule : qdac_command_port
`default_nettype wire

// ### src/qdac_pkg.sv
// Types shared by the quad converter command port
package qdac_pkg;
    typedef enum logic [7:0] {
        QDAC_IDLE     = 8'h01,
        QDAC_ADDR     = 8'h02,
        QDAC_ADDR_ACK = 8'h04,
        QDAC_RX       = 8'h08,
        QDAC_RX_ACK   = 8'h10,
        QDAC_TX       = 8'h20,
        QDAC_TX_ACK   = 8'h40,
        QDAC_IGNORE   = 8'h80
    } qdac_state_e;
    typedef logic [3:0][15:0] qdac_bank_t;
    typedef logic [7:0]       qdac_pwr_t;
endpackage : qdac_pkg

// ### verification/qdac_i2c_master.sv
// Bus master model that drives the command port's link pins
`timescale 1ns/1ps
`default_nettype none
module qdac_i2c_master (
    input  wire logic mclk,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic gap(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : gap
    // Start or repeated start, SCL left low
    task automatic start();
        gap(4);
        sda_low = 1'b0;
        gap(4);
        scl = 1'b1;
        gap(8);
        sda_low = 1'b1;
        gap(8);
        scl = 1'b0;
    endtask : start
    task automatic stop();
        gap(4);
        sda_low = 1'b1;
        gap(4);
        scl = 1'b1;
        gap(8);
        sda_low = 1'b0;
        gap(8);
    endtask : stop
    // SDA moves mid-low, sampled at the end of the high phase
    task automatic bit_xfer(input logic b, output logic got);
        gap(4);
        sda_low = ~b;
        gap(4);
        scl = 1'b1;
        gap(8);
        got = sda_line;
        scl = 1'b0;
    endtask : bit_xfer
    task automatic send(input logic [7:0] v, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--) bit_xfer(v[i], g);
        bit_xfer(1'b1, g);
        ack = ~g;
    endtask : send
    task automatic recv(input logic ack, output logic [7:0] v);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, g);
            v[i] = g;
        end
        bit_xfer(~ack, g);
    endtask : recv
endmodule : qdac_i2c_master
`default_nettype wire

// ### verification/tb.sv
// Self-checking bench of the quad converter command port and its FIFO
`timescale 1ns/1ps
`default_nettype none
`define QDAC_CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
    $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module tb;
    import qdac_pkg::*;
    logic        mclk, resetn, scl, sda_low, sda_o, sda_oe, frame_busy;
    logic        addr_pin_hi, addr_pin_lo, load_outputs_n;
    qdac_bank_t  input_reg, dac_reg, exp_in, exp_dac;
    qdac_pwr_t   chan_pwr_mode, exp_pwr;
    wire         sda_line;
    int          errors, check_count;
    logic [31:0] rng;
    logic [63:0] exp_q[$], got_q[$];
    // Open-drain line with pull-up
    assign sda_line = ~(sda_low | (sda_oe & ~sda_o));
    qdac_command_port u_qdac_command_port (.mclk(mclk), .resetn(resetn), .scl_i(scl),
        .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .addr_pin_hi(addr_pin_hi),
        .addr_pin_lo(addr_pin_lo), .load_outputs_n(load_outputs_n), .input_reg(input_reg),
        .dac_reg(dac_reg), .chan_pwr_mode(chan_pwr_mode), .frame_busy(frame_busy));
    qdac_i2c_master u_qdac_i2c_master (.mclk(mclk), .sda_line(sda_line), .scl(scl),
        .sda_low(sda_low));
    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : xs
    function automatic logic [7:0] addr_b(input logic rw);
        return {5'b00011, addr_pin_hi, addr_pin_lo, rw};
    endfunction : addr_b
    task automatic expect_eq(input logic [63:0] got, input logic [63:0] exp);
        got_q.push_back(got);
        exp_q.push_back(exp);
    endtask : expect_eq
    always @(posedge mclk) begin : observe
        logic [63:0] g, e;
        while (got_q.size() > 0) begin
            g = got_q.pop_front();
            e = exp_q.pop_front();
            `QDAC_CHK(g, e)
        end
    end
    task automatic give_verdict();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : give_verdict
    task automatic frame(input logic [7:0] cmd, input logic [15:0] d, input logic hit);
        logic a;
        u_qdac_i2c_master.start();
        u_qdac_i2c_master.send(addr_b(1'b0) ^ {~hit, 7'h00}, a);
        expect_eq(64'(a), 64'(hit));
        u_qdac_i2c_master.send(cmd, a);
        expect_eq(64'(a), 64'(hit));
        u_qdac_i2c_master.send(d[15:8], a);
        u_qdac_i2c_master.send(d[7:0], a);
        expect_eq(64'(a), 64'(hit));
        u_qdac_i2c_master.stop();
        repeat (8) @(posedge mclk);
        #1;
        for (int c = 0; c < 4; c++) begin
            if (hit && cmd[c] && cmd[7:4] inside {4'h1, 4'h3})
                exp_in[c] = d;
            if (hit && cmd[c] && cmd[7:4] inside {4'h2, 4'h3})
                exp_dac[c] = exp_in[c];
        end
        if (hit && cmd[7:4] == 4'h4)
            exp_pwr = d[7:0];
        if (!load_outputs_n)
            exp_dac = exp_in;
        expect_eq(input_reg, exp_in);
        expect_eq(dac_reg, exp_dac);
        expect_eq(64'(chan_pwr_mode), 64'(exp_pwr));
    endtask : frame
    task automatic readback(input logic [3:0] sel, input int first, input int words);
        logic       a;
        logic [7:0] hi, lo;
        u_qdac_i2c_master.start();
        u_qdac_i2c_master.send(addr_b(1'b0), a);
        u_qdac_i2c_master.send({4'h0, sel}, a);
        u_qdac_i2c_master.start();
        u_qdac_i2c_master.send(addr_b(1'b1), a);
        expect_eq(64'(a), 64'h1);
        for (int w = 0; w < words; w++) begin
            u_qdac_i2c_master.recv(1'b1, hi);
            u_qdac_i2c_master.recv(w < words - 1, lo);
            expect_eq(64'({hi, lo}), 64'(exp_in[(first + w) % 4]));
        end
        u_qdac_i2c_master.stop();
    endtask : readback
    // Frame with a fourth byte: the queued frame runs once, the extra byte is refused
    task automatic frame_extra(input logic [15:0] d);
        logic a;
        u_qdac_i2c_master.start();
        u_qdac_i2c_master.send(addr_b(1'b0), a);
        u_qdac_i2c_master.send(8'h1F, a);
        expect_eq(64'(frame_busy), 64'h1);
        u_qdac_i2c_master.send(d[15:8], a);
        u_qdac_i2c_master.send(d[7:0], a);
        expect_eq(64'(a), 64'h1);
        expect_eq(64'(frame_busy), 64'h0);
        u_qdac_i2c_master.send(~d[7:0], a);
        expect_eq(64'(a), 64'h0);
        u_qdac_i2c_master.stop();
        repeat (8) @(posedge mclk);
        #1;
        exp_in = {4{d}};
        expect_eq(input_reg, exp_in);
        expect_eq(dac_reg, exp_dac);
    endtask : frame_extra
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    initial begin
        repeat (100000) @(posedge mclk);
        errors++;
        $display("mismatch at %0t: run did not finish", $time);
        give_verdict();
    end
    initial begin : main
        rng = 32'hEBE8;
        errors = 0;
        check_count = 0;
        resetn = 1'b0;
        load_outputs_n = 1'b1;
        {exp_in, exp_dac, exp_pwr} = '0;
        {addr_pin_hi, addr_pin_lo} = 2'(xs());
        repeat (2) @(posedge mclk);
        #1;
        resetn = 1'b1;
        repeat (4) @(posedge mclk);
        #1;
        frame(8'h1F, 16'(xs()), 1'b0);
        for (int k = 1; k <= 4; k++)
            frame({4'(k), 4'hF}, 16'(xs()), 1'b1);
        for (int n = 0; n < 10; n++) begin
            {addr_pin_hi, addr_pin_lo} = 2'(xs());
            repeat (6) @(posedge mclk);
            #1;
            frame({4'(n % 5), 4'(xs())}, 16'(xs()), 1'b1);
        end
        frame(8'h1F, 16'(xs()), 1'b1);
        load_outputs_n = 1'b0;
        repeat (6) @(posedge mclk);
        #1;
        exp_dac = exp_in;
        expect_eq(dac_reg, exp_dac);
        frame(8'h15, 16'(xs()), 1'b1);
        load_outputs_n = 1'b1;
        frame(8'h40, 16'(xs()), 1'b1);
        frame(8'h3A, 16'(xs()), 1'b1);
        readback(4'h2, 1, 4);
        readback(4'h8, 3, 2);
        readback(4'h6, 0, 1);
        frame_extra(16'(xs()));
        repeat (2) @(posedge mclk);
        give_verdict();
    end
endmodule : tb
`default_nettype wire
